//--- verification/cmc_mode_control_test.sv
`timescale 1ns/1ps
module cmc_mode_control_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        bus_receive_pin_i;
  logic        bus_transmit_pin_o;
  logic        bus_transmit_pin_oe_n_o;
  logic        core_tx_i;
  logic        core_rx_o;
  logic        all_tx_aborted_i;
  logic        rx_msg_done_i;
  logic        cpu_idle_i;
  logic        abort_all_transmit_o;
  logic        capture_event_o;
  logic        window_select_o;
  logic        halt_o;
  logic [2:0]  current_mode_o;
  logic        ack_enable_o;
  logic        error_flag_enable_o;
  logic        error_counter_enable_o;
  logic        ignore_errors_o;
  logic        accept_all_o;
  int          error_cnt;
  int          checks_done;
  int          cyc_cnt;
  integer      seed;

  cmc_mode_control cmc_mode_control_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .bus_receive_pin_i(bus_receive_pin_i), .bus_transmit_pin_o(bus_transmit_pin_o),
    .bus_transmit_pin_oe_n_o(bus_transmit_pin_oe_n_o), .core_tx_i(core_tx_i), .core_rx_o(core_rx_o),
    .all_tx_aborted_i(all_tx_aborted_i), .rx_msg_done_i(rx_msg_done_i), .cpu_idle_i(cpu_idle_i),
    .abort_all_transmit_o(abort_all_transmit_o), .capture_event_o(capture_event_o),
    .window_select_o(window_select_o), .halt_o(halt_o), .current_mode_o(current_mode_o),
    .ack_enable_o(ack_enable_o), .error_flag_enable_o(error_flag_enable_o),
    .error_counter_enable_o(error_counter_enable_o), .ignore_errors_o(ignore_errors_o),
    .accept_all_o(accept_all_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] exp_reg(input logic [15:0] d, input logic [2:0] cur);
    exp_reg = {2'h0, d[13:12], 1'b0, d[10:8], cur, 1'b0, d[3], 2'h0, d[0]};
  endfunction : exp_reg

  // Result order: ack, error flag, error count, ignore, accept, oe_n
  function automatic logic [5:0] exp_dec(input logic [2:0] m);
    case (m)
      3'h0:    exp_dec = 6'h38;
      3'h2:    exp_dec = 6'h39;
      3'h7:    exp_dec = 6'h07;
      default: exp_dec = 6'h01;
    endcase
  endfunction : exp_dec

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Waits for ack without assuming a latency; only the bound ends a hang
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_xfer

  task automatic give_verdict;
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [2:0]  modes [6];
    logic [15:0] d;
    logic [31:0] q;
    int          n;
    modes = '{3'h0, 3'h2, 3'h3, 3'h7, 3'h1, 3'h4};
    seed = 32'h5e082728;
    error_cnt = 0; checks_done = 0; cyc_cnt = 0;
    rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00;
    wb_sel_i = 4'h3; wb_dat_i = 32'h0; bus_receive_pin_i = 1'b1; core_tx_i = 1'b0;
    all_tx_aborted_i = 1'b0; rx_msg_done_i = 1'b0; cpu_idle_i = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, 8'h00, 16'h0, q);
    chk(q, 32'h0480);
    // Random fields, legal mode codes only, reserved bit kept clear
    for (int i = 0; i < 6; i++) begin
      d = 16'($random(seed));
      d[11] = 1'b0;
      d[12] = 1'b0;
      d[10:8] = modes[i];
      wb_xfer(1'b1, 8'h00, d, q);
      if (modes[i] == 3'h1) begin
        repeat (5) @(posedge clk_i);
        #1;
        chk(current_mode_o, 3'h7);
        n = 0;
        while (current_mode_o !== 3'h1 && n < 400) begin
          @(posedge clk_i);
          #1;
          n++;
        end
        chk(n > 200, 1'b1);
      end else begin
        @(posedge clk_i);
        #1;
      end
      chk(current_mode_o, modes[i]);
      wb_xfer(1'b0, 8'h00, 16'h0, q);
      chk(q, {16'h0, exp_reg(d, modes[i])});
      chk(window_select_o, d[0]);
      chk({ack_enable_o, error_flag_enable_o, error_counter_enable_o, ignore_errors_o, accept_all_o,
           bus_transmit_pin_oe_n_o}, exp_dec(modes[i]));
      @(posedge clk_i);
      core_tx_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      chk(core_rx_o, modes[i] != 3'h2);
      chk(bus_transmit_pin_o, 1'b0);
      @(posedge clk_i);
      core_tx_i         <= 1'b1;
      bus_receive_pin_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      chk(core_rx_o, modes[i] == 3'h2);
      chk(bus_transmit_pin_o, 1'b1);
      @(posedge clk_i);
      core_tx_i         <= 1'b0;
      bus_receive_pin_i <= 1'b1;
    end
    // Capture on and off, mode left in configuration
    for (int en = 1; en >= 0; en--) begin
      d = {8'h04, 4'h0, en[0], 3'h0};
      wb_xfer(1'b1, 8'h00, d, q);
      @(posedge clk_i);
      rx_msg_done_i <= 1'b1;
      @(posedge clk_i);
      rx_msg_done_i <= 1'b0;
      #1;
      chk(capture_event_o, en[0]);
      @(posedge clk_i);
      #1;
      chk(capture_event_o, 1'b0);
    end
    // Abort set, then cleared by the buffers reporting completion
    wb_xfer(1'b1, 8'h00, 16'h1400, q);
    wb_xfer(1'b0, 8'h00, 16'h0, q);
    chk(q, 32'h1480);
    chk(abort_all_transmit_o, 1'b1);
    @(posedge clk_i);
    all_tx_aborted_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    all_tx_aborted_i <= 1'b0;
    wb_xfer(1'b0, 8'h00, 16'h0, q);
    chk(q, 32'h0480);
    chk(abort_all_transmit_o, 1'b0);
    // Idle-stop against processor idle, all four pairings
    for (int s = 0; s < 4; s++) begin
      wb_xfer(1'b1, 8'h00, {2'h0, s[1], 5'h04, 8'h00}, q);
      @(posedge clk_i);
      cpu_idle_i <= s[0];
      @(posedge clk_i);
      #1;
      chk(halt_o, s[1] & s[0]);
    end
    // Unmapped word: acked, reads zero, leaves the register alone
    wb_xfer(1'b1, 8'h04, 16'hFFFF, q);
    wb_xfer(1'b0, 8'h04, 16'h0, q);
    chk(q, 32'h0);
    wb_xfer(1'b0, 8'h00, 16'h0, q);
    chk(q, 32'h2480);
    give_verdict();
  end
endmodule : cmc_mode_control_test

//--- verilog/cmc_defines.svh
// What this block does
// - Requested-mode codes: 000 normal, 001 disable, 010 loopback, 011 listen, 100 config, 111 all.
// - Read-only current-mode field reports the mode actually in force, same encoding.
// - Abort-all bit aborts every transmit buffer; hardware clears it when all are aborted.
// - Capture enable set: each received message gives a capture event; clear: none.
// - Window select picks filter registers when 1, buffer registers when 0.
// - Bits 15-14, 11, 4 and 2-1 read as zero and ignore writes.
// - Disable request while active waits for 11 recessive bits, then reports 001.
// - Listen only: passive, no acknowledge, no error flags, error counters inactive.
// - Loopback: internal transmit feeds internal receive; both pins return to port function.
// - Listen all messages: errors ignored, any message accepted.
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define CMC_REG_MODE_CTRL 8'h00
`define CMC_BIT_IDLE_STOP 13
`define CMC_BIT_ABORT     12
`define CMC_REQ_HI        10
`define CMC_REQ_LO        8
`define CMC_CUR_HI        7
`define CMC_CUR_LO        5
`define CMC_BIT_CAP_EN    3
`define CMC_BIT_WIN       0
`define CMC_RST_MODE      3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CMC_CLK_MHZ   20
`define CMC_BIT_NS    1000
`define CMC_BIT_CYC   ((`CMC_BIT_NS * `CMC_CLK_MHZ) / 1000)
`define CMC_IDLE_BITS 4'hB

`endif

//--- verilog/cmc_mode_control.sv
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "cmc_defines.svh"
module cmc_mode_control (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        bus_receive_pin_i,
  output logic             bus_transmit_pin_o,
  output logic             bus_transmit_pin_oe_n_o,
  input  wire logic        core_tx_i,
  output logic             core_rx_o,
  input  wire logic        all_tx_aborted_i,
  input  wire logic        rx_msg_done_i,
  input  wire logic        cpu_idle_i,
  output logic             abort_all_transmit_o,
  output logic             capture_event_o,
  output logic             window_select_o,
  output logic             halt_o,
  output logic      [2:0]  current_mode_o,
  output logic             ack_enable_o,
  output logic             error_flag_enable_o,
  output logic             error_counter_enable_o,
  output logic             ignore_errors_o,
  output logic             accept_all_o
);

  cmc_pkg::cmc_state_type state_ff;
  cmc_pkg::cmc_state_type nxt_state;
  logic                   req_ok;
  logic                   bit_tick;
  logic                   hit;
  logic                   reg_sel;

  cmc_mode_if mif ();

  cmc_mode_decode cmc_mode_decode_inst (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .mif   (mif.decoder)
  );

  assign mif.mode = state_ff.cur;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    hit       = wb_cyc_i && wb_stb_i && !state_ff.ack;
    reg_sel   = {wb_adr_i[7:2], 2'h0} == `CMC_REG_MODE_CTRL;
    bit_tick  = 1'b0;
    req_ok    = 1'b1;

    // Only the second flop of the pin synchroniser is ever read
    nxt_state.rx_sync = {state_ff.rx_sync[0], bus_receive_pin_i};
    nxt_state.capture = rx_msg_done_i && state_ff.cap_en;
    nxt_state.ack     = hit;

    // Bit-time divider frozen while halted, so an idle period never counts as bus idle
    if (!halt_o) begin
      if (state_ff.div == 5'(`CMC_BIT_CYC - 1)) begin
        nxt_state.div = 5'h00;
        bit_tick      = 1'b1;
      end else begin
        nxt_state.div = state_ff.div + 5'h01;
      end
    end
    if (bit_tick) begin
      if (!state_ff.rx_sync[1]) begin
        nxt_state.idle_cnt = 4'h0;
      end else if (state_ff.idle_cnt != `CMC_IDLE_BITS) begin
        nxt_state.idle_cnt = state_ff.idle_cnt + 4'h1;
      end
    end

    unique case (state_ff.req)
      cmc_pkg::MODE_NORMAL, cmc_pkg::MODE_DISABLE, cmc_pkg::MODE_LOOPBACK,
      cmc_pkg::MODE_LISTEN, cmc_pkg::MODE_CONFIG, cmc_pkg::MODE_LISTEN_ALL: begin
        req_ok = 1'b1;
      end
      default: begin
        req_ok = 1'b0;
      end
    endcase

    // Mode transition; current mode moves only when the new mode is in force
    unique case (state_ff.xfer)
      cmc_pkg::XF_STABLE: begin
        if (req_ok && state_ff.req != state_ff.cur) begin
          if (state_ff.req == cmc_pkg::MODE_DISABLE && state_ff.cur != cmc_pkg::MODE_CONFIG) begin
            nxt_state.xfer     = cmc_pkg::XF_WAIT_IDLE;
            nxt_state.idle_cnt = 4'h0;
          end else begin
            nxt_state.cur = state_ff.req;
          end
        end
      end
      cmc_pkg::XF_WAIT_IDLE: begin
        if (state_ff.req != cmc_pkg::MODE_DISABLE) begin
          nxt_state.xfer = cmc_pkg::XF_STABLE;
        end else if (state_ff.idle_cnt == `CMC_IDLE_BITS) begin
          nxt_state.cur  = cmc_pkg::MODE_DISABLE;
          nxt_state.xfer = cmc_pkg::XF_STABLE;
        end
      end
    endcase

    if (state_ff.abort && all_tx_aborted_i) begin
      nxt_state.abort = 1'b0;
    end

    // Register write; placed after the hardware clear so a set in the same cycle wins
    if (hit && wb_we_i && reg_sel) begin
      if (wb_sel_i[1]) begin
        nxt_state.idle_stop = wb_dat_i[`CMC_BIT_IDLE_STOP];
        nxt_state.abort     = wb_dat_i[`CMC_BIT_ABORT] || nxt_state.abort;
        nxt_state.req       = cmc_pkg::cmc_mode_type'(wb_dat_i[`CMC_REQ_HI:`CMC_REQ_LO]);
      end
      if (wb_sel_i[0]) begin
        nxt_state.cap_en = wb_dat_i[`CMC_BIT_CAP_EN];
        nxt_state.window_select    = wb_dat_i[`CMC_BIT_WIN];
      end
    end

    // Unimplemented and reserved positions always read zero
    nxt_state.rdata = 16'h0000;
    if (hit && !wb_we_i && reg_sel) begin
      nxt_state.rdata = {2'h0, state_ff.idle_stop, state_ff.abort, 1'h0, state_ff.req,
                         state_ff.cur, 1'h0, state_ff.cap_en, 2'h0, state_ff.window_select};
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff          <= '0;
      state_ff.req      <= cmc_pkg::cmc_mode_type'(`CMC_RST_MODE);
      state_ff.cur      <= cmc_pkg::cmc_mode_type'(`CMC_RST_MODE);
      state_ff.rx_sync  <= 2'h3;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o                = state_ff.ack;
  assign wb_dat_o                = {16'h0000, state_ff.rdata};
  assign abort_all_transmit_o    = state_ff.abort;
  assign capture_event_o         = state_ff.capture;
  assign window_select_o         = state_ff.window_select;
  assign halt_o                  = state_ff.idle_stop && cpu_idle_i;
  assign current_mode_o          = state_ff.cur;
  assign core_rx_o               = mif.loopback ? core_tx_i : state_ff.rx_sync[1];
  assign bus_transmit_pin_o      = core_tx_i;
  assign bus_transmit_pin_oe_n_o = !mif.tx_drive;
  assign ack_enable_o            = mif.ack_en;
  assign error_flag_enable_o     = mif.err_flag_en;
  assign error_counter_enable_o  = mif.err_cnt_en;
  assign ignore_errors_o         = mif.ignore_err;
  assign accept_all_o            = mif.accept_all;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_enter_mode;
    state_ff.xfer == cmc_pkg::XF_STABLE && req_ok && state_ff.req != state_ff.cur &&
    state_ff.req != cmc_pkg::MODE_DISABLE |=> state_ff.cur == $past(state_ff.req);
  endproperty
  a_enter_mode: assert property (p_enter_mode) else $error("requested mode not entered");

  property p_cur_follows_req;
    !$stable(state_ff.cur) |-> state_ff.cur == $past(state_ff.req);
  endproperty
  a_cur_follows_req: assert property (p_cur_follows_req) else $error("current mode moved off request");

  property p_disable_idle;
    $rose(state_ff.cur == cmc_pkg::MODE_DISABLE) && $past(state_ff.xfer == cmc_pkg::XF_WAIT_IDLE)
      |-> $past(state_ff.idle_cnt) == `CMC_IDLE_BITS;
  endproperty
  a_disable_idle: assert property (p_disable_idle) else $error("disable entered before bus idle");

  property p_abort_clear;
    abort_all_transmit_o && all_tx_aborted_i && !(hit && wb_we_i) |=> !abort_all_transmit_o;
  endproperty
  a_abort_clear: assert property (p_abort_clear) else $error("abort not cleared");

  property p_abort_hold;
    abort_all_transmit_o && !all_tx_aborted_i |=> abort_all_transmit_o;
  endproperty
  a_abort_hold: assert property (p_abort_hold) else $error("abort dropped early");

  property p_capture;
    rx_msg_done_i |=> capture_event_o == $past(state_ff.cap_en);
  endproperty
  a_capture: assert property (p_capture) else $error("capture event mismatch");

  property p_window;
    hit && wb_we_i && reg_sel && wb_sel_i[0] |=> window_select_o == $past(wb_dat_i[`CMC_BIT_WIN]);
  endproperty
  a_window: assert property (p_window) else $error("window select not written");

  property p_read_zero;
    wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:14] == 18'h00000 && wb_dat_o[11] == 1'b0 &&
                                    wb_dat_o[4] == 1'b0 && wb_dat_o[2:1] == 2'h0;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unimplemented bits not zero");

  property p_read_mode;
    hit && !wb_we_i && reg_sel |=> wb_dat_o[`CMC_CUR_HI:`CMC_CUR_LO] == $past(state_ff.cur);
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("current mode read wrong");

  // A disable request still restarts the idle count while halted; only bit ticks must stop
  property p_halt_freeze;
    halt_o |=> $stable(state_ff.div) &&
               ($stable(state_ff.idle_cnt) || $rose(state_ff.xfer == cmc_pkg::XF_WAIT_IDLE));
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("controller ran while halted");

  c_disable: cover property ($rose(state_ff.cur == cmc_pkg::MODE_DISABLE));
  c_abort_done: cover property ($fell(abort_all_transmit_o));
  c_loopback: cover property (state_ff.cur == cmc_pkg::MODE_LOOPBACK);
  c_capture: cover property (capture_event_o);

endmodule : cmc_mode_control

//--- verilog/cmc_mode_decode.sv
`timescale 1ns/1ps
module cmc_mode_decode (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  cmc_mode_if.decoder mif
);

  // ----------------------------------------------------------------
  // Per-mode enables
  // ----------------------------------------------------------------
  always_comb begin
    mif.tx_drive    = 1'b0;
    mif.ack_en      = 1'b0;
    mif.err_flag_en = 1'b0;
    mif.err_cnt_en  = 1'b0;
    mif.ignore_err  = 1'b0;
    mif.accept_all  = 1'b0;
    mif.loopback    = 1'b0;
    unique case (mif.mode)
      cmc_pkg::MODE_NORMAL: begin
        mif.tx_drive    = 1'b1;
        mif.ack_en      = 1'b1;
        mif.err_flag_en = 1'b1;
        mif.err_cnt_en  = 1'b1;
      end
      cmc_pkg::MODE_DISABLE: begin
      end
      cmc_pkg::MODE_LOOPBACK: begin
        mif.loopback    = 1'b1;
        mif.ack_en      = 1'b1;
        mif.err_flag_en = 1'b1;
        mif.err_cnt_en  = 1'b1;
      end
      cmc_pkg::MODE_LISTEN: begin
        // Passive on the bus: transmitter left as a port pin
      end
      cmc_pkg::MODE_CONFIG: begin
      end
      cmc_pkg::MODE_LISTEN_ALL: begin
        mif.ignore_err  = 1'b1;
        mif.accept_all  = 1'b1;
      end
      default: begin
        // Reserved codes never become the current mode; stay quiet
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_listen_passive;
    @(posedge clk_i) disable iff (rst_i)
    mif.mode == cmc_pkg::MODE_LISTEN |-> !mif.ack_en && !mif.err_flag_en && !mif.err_cnt_en && !mif.tx_drive;
  endproperty
  a_listen_passive: assert property (p_listen_passive) else $error("listen only not passive");

  property p_loopback_route;
    @(posedge clk_i) disable iff (rst_i)
    mif.mode == cmc_pkg::MODE_LOOPBACK |-> mif.loopback && !mif.tx_drive;
  endproperty
  a_loopback_route: assert property (p_loopback_route) else $error("loopback routing wrong");

  property p_listen_all;
    @(posedge clk_i) disable iff (rst_i)
    mif.mode == cmc_pkg::MODE_LISTEN_ALL |-> mif.ignore_err && mif.accept_all && !mif.err_flag_en;
  endproperty
  a_listen_all: assert property (p_listen_all) else $error("listen all not accepting");

endmodule : cmc_mode_decode

//--- verilog/cmc_mode_if.sv
`timescale 1ns/1ps
interface cmc_mode_if;
  cmc_pkg::cmc_mode_type mode;
  logic                  tx_drive;
  logic                  ack_en;
  logic                  err_flag_en;
  logic                  err_cnt_en;
  logic                  ignore_err;
  logic                  accept_all;
  logic                  loopback;

  modport decoder (input mode, output tx_drive, ack_en, err_flag_en, err_cnt_en, ignore_err, accept_all, loopback);
  modport core (output mode, input tx_drive, ack_en, err_flag_en, err_cnt_en, ignore_err, accept_all, loopback);
endinterface : cmc_mode_if

//--- verilog/cmc_pkg.sv
package cmc_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL     = 3'b000,
    MODE_DISABLE    = 3'b001,
    MODE_LOOPBACK   = 3'b010,
    MODE_LISTEN     = 3'b011,
    MODE_CONFIG     = 3'b100,
    MODE_LISTEN_ALL = 3'b111
  } cmc_mode_type;

  typedef enum logic {
    XF_STABLE    = 1'b0,
    XF_WAIT_IDLE = 1'b1
  } cmc_xfer_type;

  typedef struct packed {
    logic         idle_stop;
    logic         abort;
    cmc_mode_type req;
    cmc_mode_type cur;
    logic         cap_en;
    logic         window_select;
    cmc_xfer_type xfer;
    logic [4:0]   div;
    logic [3:0]   idle_cnt;
    logic         ack;
    logic [15:0]  rdata;
    logic         capture;
    logic [1:0]   rx_sync;
  } cmc_state_type;

endpackage : cmc_pkg
